// ===== common/agen_cfg.svh
`ifndef AGEN_CFG_SVH
`define AGEN_CFG_SVH
`define OFS_CORE_CTRL   8'h00
`define OFS_WIN_PAGE    8'h04
`define OFS_STK_LIMIT   8'h08
`define OFS_STK_PTR     8'h0C
`define OFS_MOD_START   8'h10
`define OFS_MOD_END     8'h14
`define OFS_REV_STEP    8'h18
`define OFS_STATUS      8'h1C
`define BIT_WIN_EN      0
`define BIT_MOD_EN      1
`define BIT_REV_EN      2
`define BIT_ST_LIMIT    0
`define BIT_ST_UNDER    1
`define BIT_ST_YERR     2
`define SFR_TOP         16'h0800
`define NEAR_BITS       13
`define OFS_BITS        15
`define STK_STEP        16'h0002
`define SP_RESET        16'h0800
`define EXTRA_CHEAP     2'h1
`define EXTRA_FULL      2'h2
`endif

// ===== common/agen_pkg.sv
package agen_pkg;
    typedef enum logic [2:0] {
        EA_IND, EA_POST, EA_PRE, EA_BASE, EA_LIT, EA_NEAR, EA_FULL
    } ea_mode_t;
    typedef enum logic [1:0] {PUSH_DATA, PUSH_PC_LO, PUSH_CALL_HI, PUSH_EXC_HI} push_kind_t;
    typedef enum logic [2:0] {
        OP_PASS, OP_BYTE_LOAD, OP_SIGN_EXT, OP_ZERO_EXT, OP_LIT5, OP_WIN_WORD
    } dp_op_t;
    typedef struct packed {
        logic        valid;
        ea_mode_t    mode;
        logic        dec;
        logic [15:0] ptr;
        logic [15:0] base;
        logic [15:0] lit;
        logic        push;
        logic        pop;
        logic        sp_ref;
        push_kind_t  pkind;
        logic [15:0] wdata;
        logic [22:0] pc;
        logic [7:0]  status_lo;
        logic        tbl_busy;
        logic        loop_in;
        logic        loop_edge;
        logic        cheap;
        logic        y_valid;
        logic        y_mac;
        logic        y_word;
        logic [15:0] y_ptr;
    } ag_req_t;
    typedef struct packed {
        logic        valid;
        logic [15:0] ea;
        logic [15:0] new_ptr;
        logic        win_hit;
        logic [23:0] prog_addr;
        logic [1:0]  extra;
        logic        stack_err;
        logic [15:0] push_data;
        logic        y_ok;
        logic [15:0] y_ea;
    } ag_rsp_t;
    typedef struct packed {
        dp_op_t      op;
        logic [15:0] work_reg;
        logic [7:0]  byte_in;
        logic [4:0]  lit5;
        logic [23:0] pword;
    } dp_req_t;
endpackage

// ===== src/data_space_addressing_unit.sv
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "agen_cfg.svh"
module data_space_addressing_unit
    import agen_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [AW-1:0] paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire ag_req_t       req,
    output ag_rsp_t            rsp,
    input  wire dp_req_t       dp,
    output logic      [15:0]   dp_result
);
    logic [2:0]  ctrl_ff;
    logic [7:0]  page_ff;
    logic [15:0] limit_ff;
    logic [15:0] sp_ff;
    logic [15:0] mstart_ff;
    logic [15:0] mend_ff;
    logic [15:0] rstep_ff;
    logic [2:0]  stat_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    ag_rsp_t     rsp_ff;
    logic [15:0] dp_ff;

    logic        setup;
    logic        wr_go;
    logic        mapped;
    logic [31:0] rd_val;
    logic [7:0]  ofs;

    assign ofs   = 8'(paddr);
    assign setup = psel & ~penable;
    assign wr_go = psel & penable & pready_ff & pwrite & ~pslverr_ff;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (ofs)
            `OFS_CORE_CTRL: rd_val = {29'h0, ctrl_ff};
            `OFS_WIN_PAGE:  rd_val = {24'h0, page_ff};
            `OFS_STK_LIMIT: rd_val = {16'h0, limit_ff[15:1], 1'b0};
            `OFS_STK_PTR:   rd_val = {16'h0, sp_ff};
            `OFS_MOD_START: rd_val = {16'h0, mstart_ff};
            `OFS_MOD_END:   rd_val = {16'h0, mend_ff};
            `OFS_REV_STEP:  rd_val = {16'h0, rstep_ff};
            `OFS_STATUS:    rd_val = {29'h0, stat_ff};
            default:        mapped = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end
    end

    // Zero-wait slave: answer is ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup && !pwrite && mapped) begin
                prdata_ff <= rd_val;
            end else if (setup) begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= 3'h0;
            page_ff   <= 8'h00;
            mstart_ff <= 16'h0000;
            mend_ff   <= 16'h0000;
            rstep_ff  <= 16'h0000;
        end else if (wr_go) begin
            case (ofs)
                `OFS_CORE_CTRL: ctrl_ff   <= pwdata[2:0];
                `OFS_WIN_PAGE:  page_ff   <= pwdata[7:0];
                `OFS_MOD_START: mstart_ff <= pwdata[15:0];
                `OFS_MOD_END:   mend_ff   <= pwdata[15:0];
                `OFS_REV_STEP:  rstep_ff  <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // The limit is deliberately left out of reset; software must load it
    always_ff @(posedge pclk) begin
        if (wr_go && ofs == `OFS_STK_LIMIT) begin
            limit_ff <= {pwdata[15:1], 1'b0};
        end
    end

    // Address generation
    function automatic logic [15:0] bit_rev(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    logic [15:0] step;
    logic [15:0] mod_ptr;
    logic [15:0] wrap_ptr;
    logic [15:0] nxt_ea;
    logic [15:0] nxt_ptr;
    logic [15:0] nxt_sp;
    logic [15:0] nxt_push;
    logic        nxt_win;
    logic        nxt_err;
    logic [1:0]  nxt_extra;
    logic        sp_addr;
    logic        nxt_yok;

    assign step = req.dec ? -req.lit : req.lit;

    // Modulo wrap keeps a circular buffer inside start..end
    always_comb begin
        mod_ptr  = req.ptr + step;
        wrap_ptr = mod_ptr;
        if (ctrl_ff[`BIT_MOD_EN]) begin
            if (!req.dec && mod_ptr > mend_ff) begin
                wrap_ptr = mstart_ff;
            end else if (req.dec && mod_ptr < mstart_ff) begin
                wrap_ptr = mend_ff;
            end
        end
    end

    always_comb begin
        nxt_ea  = req.ptr;
        nxt_ptr = req.ptr;
        case (req.mode)
            EA_IND:  nxt_ea = req.ptr;
            EA_POST: nxt_ptr = wrap_ptr;
            EA_PRE: begin
                nxt_ea  = wrap_ptr;
                nxt_ptr = wrap_ptr;
            end
            EA_BASE: nxt_ea = req.ptr + req.base;
            EA_LIT:  nxt_ea = req.ptr + req.lit;
            EA_NEAR: nxt_ea = {3'b000, req.lit[`NEAR_BITS-1:0]};
            EA_FULL: nxt_ea = req.lit;
            default: nxt_ea = req.ptr;
        endcase
        // Reverse-carry stepping is a data-space feature only
        if (req.mode == EA_POST && ctrl_ff[`BIT_REV_EN] && !req.ptr[15]) begin
            nxt_ptr = bit_rev(bit_rev(req.ptr) + bit_rev(rstep_ff));
        end
        nxt_sp = sp_ff;
        if (req.push) begin
            nxt_ea = sp_ff;
            nxt_sp = sp_ff + `STK_STEP;
        end else if (req.pop) begin
            nxt_sp = sp_ff - `STK_STEP;
            nxt_ea = nxt_sp;
        end
    end

    always_comb begin
        case (req.pkind)
            PUSH_PC_LO:   nxt_push = req.pc[15:0];
            PUSH_CALL_HI: nxt_push = {9'h000, req.pc[22:16]};
            PUSH_EXC_HI:  nxt_push = {req.status_lo, 1'b0, req.pc[22:16]};
            default:      nxt_push = req.wdata;
        endcase
    end

    assign sp_addr = req.push | req.pop | req.sp_ref;

    always_comb begin
        nxt_err = 1'b0;
        if (req.valid && sp_addr) begin
            if (nxt_ea > {limit_ff[15:1], 1'b0}) begin
                nxt_err = 1'b1;
            end
            if (nxt_ea < `SFR_TOP) begin
                nxt_err = 1'b1;
            end
        end
    end

    // Table instructions own the program bus, so the window stands aside
    assign nxt_win = req.valid & nxt_ea[15] & ctrl_ff[`BIT_WIN_EN] & ~req.tbl_busy;

    always_comb begin
        nxt_extra = 2'h0;
        if (nxt_win) begin
            if (req.loop_in) begin
                nxt_extra = req.loop_edge ? `EXTRA_FULL : 2'h0;
            end else begin
                nxt_extra = req.cheap ? `EXTRA_CHEAP : `EXTRA_FULL;
            end
        end
    end

    assign nxt_yok = req.y_valid & req.y_mac & req.y_word;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_ff <= `SP_RESET;
        end else if (wr_go && ofs == `OFS_STK_PTR) begin
            sp_ff <= {pwdata[15:1], 1'b0};
        end else if (req.valid) begin
            sp_ff <= nxt_sp;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.valid     <= req.valid;
            rsp_ff.ea        <= nxt_ea;
            rsp_ff.new_ptr   <= nxt_ptr;
            rsp_ff.win_hit   <= nxt_win;
            rsp_ff.prog_addr <= {1'b0, page_ff, nxt_ea[`OFS_BITS-1:0]};
            rsp_ff.extra     <= nxt_extra;
            rsp_ff.stack_err <= nxt_err;
            rsp_ff.push_data <= nxt_push;
            rsp_ff.y_ok      <= nxt_yok;
            rsp_ff.y_ea      <= nxt_yok ? req.y_ptr : 16'h0000;
        end
    end

    // Sticky causes; a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_go && ofs == `OFS_STATUS && pwdata[i]) begin
                    stat_ff[i] <= 1'b0;
                end
            end
            if (nxt_err && nxt_ea < `SFR_TOP) begin
                stat_ff[`BIT_ST_UNDER] <= 1'b1;
            end
            if (nxt_err && nxt_ea >= `SFR_TOP) begin
                stat_ff[`BIT_ST_LIMIT] <= 1'b1;
            end
            if (req.y_valid && !nxt_yok) begin
                stat_ff[`BIT_ST_YERR] <= 1'b1;
            end
        end
    end

    // Working register data path
    logic [15:0] nxt_dp;
    always_comb begin
        case (dp.op)
            OP_BYTE_LOAD: nxt_dp = {dp.work_reg[15:8], dp.byte_in};
            OP_SIGN_EXT:  nxt_dp = {{8{dp.work_reg[7]}}, dp.work_reg[7:0]};
            OP_ZERO_EXT:  nxt_dp = {8'h00, dp.work_reg[7:0]};
            OP_LIT5:      nxt_dp = {11'h000, dp.lit5};
            OP_WIN_WORD:  nxt_dp = dp.pword[15:0];
            default:      nxt_dp = dp.work_reg;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp_ff <= 16'h0000;
        end else begin
            dp_ff <= nxt_dp;
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign rsp       = rsp_ff;
    assign dp_result = dp_ff;
endmodule
`default_nettype wire

// ===== sim/dsau_props.sv
`timescale 1ns/10ps
`default_nettype none
module dsau_props
    import agen_pkg::*;
(
    input wire logic          pclk,
    input wire logic          presetn,
    input wire ag_req_t       req,
    input wire ag_rsp_t       rsp,
    input wire dp_req_t       dp,
    input wire logic   [15:0] dp_result
);
    wire logic        sp_req   = req.valid & (req.push | req.pop | req.sp_ref);
    wire logic        push_req = req.valid & req.push;
    wire logic [15:0] byte_exp = {dp.work_reg[15:8], dp.byte_in};
    wire logic [15:0] pw_lo    = dp.pword[15:0];
    wire logic [1:0]  cost_exp = req.loop_in ? (req.loop_edge ? 2'h2 : 2'h0)
                                             : (req.cheap ? 2'h1 : 2'h2);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    win_map_a: assert property (rsp.win_hit |-> rsp.ea[15] && !rsp.prog_addr[23]
        && rsp.prog_addr[14:0] == rsp.ea[14:0]) else $error("window map wrong");
    tbl_off_a: assert property (req.tbl_busy |=> !rsp.win_hit)
        else $error("window during table op");
    hit_cost_a: assert property (rsp.win_hit |-> rsp.extra == $past(cost_exp))
        else $error("window cost wrong");
    miss_cost_a: assert property (!rsp.win_hit |-> rsp.extra == 2'h0)
        else $error("cost without window");
    byte_load_a: assert property (dp.op == OP_BYTE_LOAD |=> dp_result == $past(byte_exp))
        else $error("byte load wrong");
    sign_ext_a: assert property (dp.op == OP_SIGN_EXT |=> dp_result[15:8] == {8{dp_result[7]}})
        else $error("sign extend wrong");
    zero_ext_a: assert property (dp.op == OP_ZERO_EXT |=> dp_result[15:8] == 8'h00)
        else $error("zero extend wrong");
    win_word_a: assert property (dp.op == OP_WIN_WORD |=> dp_result == $past(pw_lo))
        else $error("window word wrong");
    push_step_a: assert property (push_req ##1 push_req |=> rsp.ea == $past(rsp.ea) + 16'h0002)
        else $error("push step wrong");
    under_trap_a: assert property (rsp.valid && rsp.ea < 16'h0800 && $past(sp_req) |-> rsp.stack_err)
        else $error("underflow missed");
    err_cause_a: assert property (rsp.stack_err |-> $past(sp_req))
        else $error("stray stack error");
    y_refuse_a: assert property (req.y_valid && !(req.y_mac && req.y_word) |=> !rsp.y_ok)
        else $error("Y misuse accepted");
    cover property (rsp.win_hit);
    cover property (rsp.stack_err);
    cover property (push_req ##1 push_req);
endmodule
bind data_space_addressing_unit dsau_props props_i (
    .pclk(pclk), .presetn(presetn), .req(req), .rsp(rsp), .dp(dp), .dp_result(dp_result)
);
`default_nettype wire

// ===== sim/prog_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module prog_mem_model (
    input  wire logic [23:0] addr,
    output logic      [23:0] word
);
    // Upper byte is an illegal-opcode filler so a stray fetch traps
    assign word = {8'hFF, addr[15:0] ^ 16'h3C3C};
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb
    import agen_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    ag_req_t     req = '0;
    ag_req_t     r;
    ag_rsp_t     rsp;
    dp_req_t     dp = '0;
    dp_req_t     dq = '0;
    logic [15:0] dp_result;
    logic [23:0] pw;
    logic [31:0] rdat;
    logic        rerr;
    int          n_mismatch = 0;
    int          checked = 0;
    int          i;
    logic [15:0] ex [7] = '{16'h1000, 16'h1000, 16'hF006, 16'h1100, 16'hF006, 16'h0006, 16'hE006};
    data_space_addressing_unit data_space_addressing_unit_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req(req), .rsp(rsp), .dp(dp), .dp_result(dp_result));
    prog_mem_model prog_mem_model_i (.addr(rsp.prog_addr), .word(pw));
    always #10 pclk = ~pclk;
    // Waits for pready without a limit of its own; the watchdog ends a hang
    task ab(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Holds one request for n cycles, so pushes and pops go back to back
    task burst(input int n, input logic [15:0] e, input logic [15:0] s, input logic [7:0] em);
        @(posedge pclk);
        req <= r;
        for (int j = 0; j < n; j++) begin
            @(posedge pclk);
            if (j == n - 1) req <= '0;
            #1;
            `CHK(rsp.ea, e)
            `CHK(rsp.stack_err, em[j])
            e = e + s;
        end
    endtask
    task gd(input dp_op_t o, input logic [15:0] x);
        dq.op = o;
        @(posedge pclk);
        dp <= dq;
        @(posedge pclk);
        #1;
        `CHK(dp_result, x)
    endtask
    task t_stack;
        ab(1'b1, 8'h08, 32'h0805);
        ab(1'b0, 8'h08, 32'h0);
        `CHK(rdat, 32'h0804)
        ab(1'b0, 8'h20, 32'h0);
        `CHK(rerr, 1'b1)
        r = '0;
        r.valid = 1'b1;
        r.push = 1'b1;
        burst(4, 16'h0800, 16'h0002, 8'h08);
        r.push = 1'b0;
        r.pop = 1'b1;
        burst(5, 16'h0806, 16'hFFFE, 8'h11);
    endtask
    task t_pc;
        ab(1'b1, 8'h08, 32'h2000);
        // Stack use waits past the limit write by a full transfer
        ab(1'b1, 8'h0C, 32'h1000);
        r = '0;
        r.valid = 1'b1;
        r.push = 1'b1;
        r.pc = 23'h7F1234;
        r.status_lo = 8'hC3;
        r.pkind = PUSH_PC_LO;
        burst(1, 16'h1000, 16'h0, 8'h0);
        `CHK(rsp.push_data, 16'h1234)
        r.pkind = PUSH_CALL_HI;
        burst(1, 16'h1002, 16'h0, 8'h0);
        `CHK(rsp.push_data, 16'h007F)
        r.pkind = PUSH_EXC_HI;
        burst(1, 16'h1004, 16'h0, 8'h0);
        `CHK(rsp.push_data, 16'hC37F)
    endtask
    task t_win;
        ab(1'b1, 8'h00, 32'h1);
        ab(1'b1, 8'h04, 32'hA5);
        r = '0;
        r.valid = 1'b1;
        r.ptr = 16'h8122;
        r.cheap = 1'b1;
        burst(1, 16'h8122, 16'h0, 8'h0);
        `CHK(rsp.win_hit, 1'b1)
        `CHK(rsp.prog_addr, 24'h528122)
        `CHK(rsp.extra, 2'h1)
        dq.pword = pw;
        gd(OP_WIN_WORD, pw[15:0]);
        for (i = 0; i < 8; i++) begin
            r.cheap = i[0];
            r.loop_in = i[1];
            r.loop_edge = i[2];
            burst(1, 16'h8122, 16'h0, 8'h0);
            `CHK(rsp.extra, i[1] ? (i[2] ? 2'h2 : 2'h0) : (i[0] ? 2'h1 : 2'h2))
        end
        r.tbl_busy = 1'b1;
        burst(1, 16'h8122, 16'h0, 8'h0);
        `CHK(rsp.win_hit, 1'b0)
        r.tbl_busy = 1'b0;
        r.ptr = 16'h0122;
        burst(1, 16'h0122, 16'h0, 8'h0);
        `CHK(rsp.extra, 2'h0)
        ab(1'b1, 8'h00, 32'h0);
        r.ptr = 16'h8122;
        burst(1, 16'h8122, 16'h0, 8'h0);
        `CHK(rsp.win_hit, 1'b0)
    endtask
    task t_ea;
        r = '0;
        r.valid = 1'b1;
        r.ptr = 16'h1000;
        r.base = 16'h0100;
        r.lit = 16'hE006;
        for (i = 0; i < 7; i++) begin
            r.mode = ea_mode_t'(i);
            burst(1, ex[i], 16'h0, 8'h0);
        end
        r.mode = EA_POST;
        burst(1, 16'h1000, 16'h0, 8'h0);
        `CHK(rsp.new_ptr, 16'hF006)
        r.mode = EA_PRE;
        r.dec = 1'b1;
        burst(1, 16'h2FFA, 16'h0, 8'h0);
        ab(1'b1, 8'h10, 32'h1000);
        ab(1'b1, 8'h14, 32'h1004);
        ab(1'b1, 8'h00, 32'h2);
        r.mode = EA_POST;
        r.dec = 1'b0;
        r.ptr = 16'h1004;
        r.lit = 16'h0002;
        burst(1, 16'h1004, 16'h0, 8'h0);
        `CHK(rsp.new_ptr, 16'h1000)
        r.dec = 1'b1;
        r.ptr = 16'h1000;
        burst(1, 16'h1000, 16'h0, 8'h0);
        `CHK(rsp.new_ptr, 16'h1004)
        ab(1'b1, 8'h18, 32'h4000);
        ab(1'b1, 8'h00, 32'h4);
        r.dec = 1'b0;
        r.ptr = 16'h4000;
        burst(1, 16'h4000, 16'h0, 8'h0);
        // Reverse carry: the sum of two 0x4000 steps lands one bit lower
        `CHK(rsp.new_ptr, 16'h2000)
        r.ptr = 16'hC000;
        burst(1, 16'hC000, 16'h0, 8'h0);
        `CHK(rsp.new_ptr, 16'hC002)
        ab(1'b1, 8'h00, 32'h0);
    endtask
    task t_dp;
        dq.work_reg = 16'h5A81;
        dq.byte_in = 8'h9C;
        dq.lit5 = 5'h15;
        gd(OP_BYTE_LOAD, 16'h5A9C);
        dq.work_reg = 16'h5A9C;
        gd(OP_SIGN_EXT, 16'hFF9C);
        gd(OP_ZERO_EXT, 16'h009C);
        gd(OP_LIT5, 16'h0015);
        gd(OP_PASS, 16'h5A9C);
    endtask
    task t_y;
        r = '0;
        r.valid = 1'b1;
        r.y_valid = 1'b1;
        r.y_mac = 1'b1;
        r.y_word = 1'b1;
        r.y_ptr = 16'h3456;
        burst(1, 16'h0, 16'h0, 8'h0);
        `CHK(rsp.y_ea, 16'h3456)
        r.y_mac = 1'b0;
        burst(1, 16'h0, 16'h0, 8'h0);
        `CHK(rsp.y_ok, 1'b0)
        ab(1'b0, 8'h1C, 32'h0);
        `CHK(rdat[2], 1'b1)
        `CHK(rdat[1:0], 2'h3)
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_stack;
        t_pc;
        t_win;
        t_ea;
        t_dp;
        t_y;
        wrap_up;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        n_mismatch++;
        wrap_up;
    end
endmodule
`default_nettype wire
